/* File: bench/kpi_asserts.sv */
`timescale 1ns/1ps
module kpi_asserts (
    input wire logic        clk_sys_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o, wake_o,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i, prdata_o,
    input wire logic [7:0]  port_ddr_i, pullup_en_o, pin_read_en_o
);
default clocking @(posedge clk_sys_i); endclocking
default disable iff (!nrst_i);
property p_rdy; psel_i && !penable_i |=> pready_o; endproperty
a_rdy: assert property (p_rdy) else $error("no ready after setup");
property p_err; pslverr_o |-> pready_o && paddr_i != 12'h068 && paddr_i != 12'h06c; endproperty
a_err: assert property (p_err) else $error("error on mapped address");
property p_ack; pready_o && !pwrite_i && paddr_i == 12'h068 |-> !prdata_o[2] && prdata_o[31:4] == 0; endproperty
a_ack: assert property (p_ack) else $error("ack bit read back");
property p_wake; wake_o == irq_o; endproperty
a_wake: assert property (p_wake) else $error("wake differs from irq");
property p_dir; $past(nrst_i) |-> pin_read_en_o == ~$past(port_ddr_i); endproperty
a_dir: assert property (p_dir) else $error("pin read enable wrong");
property p_msk; psel_i && penable_i && pwrite_i && paddr_i == 12'h068 && pwdata_i[1] |=> ##1 !irq_o; endproperty
a_msk: assert property (p_msk) else $error("masked irq seen");
property p_en; psel_i && penable_i && pwrite_i && paddr_i == 12'h06c
    |=> ##1 {24'h0, pullup_en_o} == ($past(pwdata_i, 2) & 32'hff); endproperty
a_en: assert property (p_en) else $error("pull-up enable wrong");
property p_rst; $rose(nrst_i) |-> pullup_en_o == 8'h00 && !irq_o; endproperty
a_rst: assert property (p_rst) else $error("state after reset");
c_irq: cover property (irq_o);
c_err: cover property (pslverr_o);
c_wr: cover property (psel_i && penable_i && pwrite_i);
endmodule // kpi_asserts

/* File: bench/kpi_keypad_model.sv */
`timescale 1ns/1ps
module kpi_keypad_model (
    input wire logic       clk_sys_i,
    input wire logic [7:0] pullup_en_i, pressed_i,
    output logic [7:0]     pins_o
);
logic [7:0] flt_q = 8'h55;
// Unpulled pins float: toggle so no level is trusted
always @(posedge clk_sys_i) flt_q <= ~flt_q;
assign pins_o = ~pressed_i & (pullup_en_i | flt_q);
endmodule // kpi_keypad_model

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
localparam logic [11:0] sc = 12'h068, ie = 12'h06c;
logic clk_sys_i = 0, nrst_i = 0, psel = 0, pen = 0, pwr = 0, vf = 0, brk = 0, bce = 0, rdy, err, irq, e;
logic [11:0] pa = 0;
logic [31:0] pwd = 0, prd, r;
logic [7:0] prs = 0, ddr = 8'h0f, pins, pu;
int fail_count = 0, checks = 0;
always #5 clk_sys_i = ~clk_sys_i;
kpi_keypad_irq_unit i_dut (.clk_sys_i, .nrst_i, .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
    .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err), .keypad_input_pins_i(pins), .port_ddr_i(ddr),
    .vector_fetch_i(vf), .break_state_i(brk), .break_clear_enable_i(bce), .pullup_en_o(pu), .force_input_o(),
    .pin_read_en_o(), .irq_o(irq), .wake_o());
kpi_keypad_model i_pad (.clk_sys_i, .pullup_en_i(pu), .pressed_i(prs), .pins_o(pins));
task chk(input logic [31:0] s, x);
    checks++;
    if (s !== x) begin
        fail_count++;
        $display("CHECK FAILED %0t got %h exp %h", $time, s, x);
    end
endtask
task results;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask
task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_sys_i) {psel, pa, pwr, pwd} <= {1'b1, a, w, d};
    @(posedge clk_sys_i) pen <= 1;
    n = 0;
    // Ready and data are taken at the rising edge, pre-edge values
    do begin
        @(posedge clk_sys_i);
        n++;
    end while (rdy !== 1 && n < 50);
    if (rdy !== 1) begin
        fail_count++;
        results;
    end
    r = prd;
    e = err;
    {psel, pen} <= 2'b00;
endtask
task st(input logic [31:0] x); apb(sc, 0, 0); chk(r, x); endtask
task key(input logic [7:0] v); @(posedge clk_sys_i) prs <= v; repeat (6) @(posedge clk_sys_i); endtask
initial begin
    repeat (10) @(posedge clk_sys_i);
    nrst_i <= 1;
    st(0);
    apb(ie, 0, 0); chk(r, 0);
    apb(12'h070, 0, 0); chk(e, 1);
    apb(sc, 1, 2); apb(ie, 1, 'h0f); apb(sc, 1, 6); apb(sc, 1, 0);
    @(negedge clk_sys_i) chk(pu, 8'h0f);
    key(1); @(negedge clk_sys_i) chk(irq, 1);
    st(8);
    apb(sc, 1, 4); key(3); st(0);
    key(0); key(2); st(8);
    @(posedge clk_sys_i) vf <= 1;
    @(posedge clk_sys_i) vf <= 0;
    st(0);
    key(0); apb(sc, 1, 1); key(4); apb(sc, 1, 5); st(9);
    key(0); st(1);
    apb(sc, 1, 0); brk <= 1; key(8); apb(sc, 1, 4); st(8);
    bce <= 1; apb(sc, 1, 4); brk <= 0; st(0);
    key(0); apb(sc, 1, 2); key(1); @(negedge clk_sys_i) chk(irq, 0);
    st(10);
    nrst_i <= 0; key(4); nrst_i <= 1; st(0);
    results;
end
endmodule // tb_top
bind kpi_keypad_irq_unit kpi_asserts u_chk (.clk_sys_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .pready_o,
    .pslverr_o, .irq_o, .wake_o, .paddr_i, .pwdata_i, .prdata_o, .port_ddr_i, .pullup_en_o, .pin_read_en_o);

/* File: inc/kpi_map.vh */
// Contract
// RQ1 - Eight inputs, each enabled by own bit, feeding one common request.
// RQ2 - Enabling a pin also turns on its pull-up; disabling removes it.
// RQ3 - Latch request when an enabled input falls while all were high.
// RQ4 - Edge-only: no new request while another enabled input is low.
// RQ5 - Edge-level: request held while low; clears after ack and all high.
// RQ6 - Edge-only: vector fetch or software ack clears request at once.
// RQ7 - Writing one to write-only ack bit clears latch; reads zero.
// RQ8 - Ack does not block later edges; a new fall latches again.
// RQ9 - Unmasked latched request directs CPU to the keypad vector.
// RQ10 - Pending flag shows latch regardless of mask; reset clears it.
// RQ11 - Mask one hides request from CPU; zero presents it; reset clears.
// RQ12 - Sensitivity one: falling edges and low levels; zero: edges only.
// RQ13 - Reset clears latch and sensitivity bit even with input low.
// RQ14 - Reset clears all eight enable bits.
// RQ15 - Enable forces pin to input; pin readable only with direction zero.
// RQ16 - Logic runs in wait and stop; unmasked request wakes processor.
// RQ17 - In break with clear-enable one, ack clears latch; stays cleared.
// RQ18 - In break with clear-enable zero, ack leaves latch unchanged.
// RQ19 - Software masks, enables, acks, then unmasks at init.
// RQ20 - Inputs synchronised before edge detection on registered samples.
`ifndef KPI_MAP_VH
`define KPI_MAP_VH
`define KPI_OFS_STATUS_CONTROL 12'h01a
`define KPI_OFS_INPUT_ENABLE   12'h01b
`define KPI_ADDR_STATUS_CONTROL 12'h068
`define KPI_ADDR_INPUT_ENABLE   12'h06c
`define KPI_BIT_SENSITIVITY 0
`define KPI_BIT_MASK        1
`define KPI_BIT_ACK         2
`define KPI_BIT_PENDING     3
`define KPI_RST_CTRL        1'b0
`define KPI_RST_ENABLE      8'h00
`endif

/* File: logic/kpi_keypad_irq_unit.v */
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "kpi_map.vh"
module kpi_keypad_irq_unit #(
    parameter N = 8
) (
    input  wire          clk_sys_i,
    input  wire          nrst_i,
    input  wire          psel_i,
    input  wire          penable_i,
    input  wire          pwrite_i,
    input  wire [11:0]   paddr_i,
    input  wire [31:0]   pwdata_i,
    output reg  [31:0]   prdata_o,
    output reg           pready_o,
    output reg           pslverr_o,
    input  wire [N-1:0]  keypad_input_pins_i,
    input  wire [N-1:0]  port_ddr_i,
    input  wire          vector_fetch_i,
    input  wire          break_state_i,
    input  wire          break_clear_enable_i,
    output reg  [N-1:0]  pullup_en_o,
    output reg  [N-1:0]  force_input_o,
    output reg  [N-1:0]  pin_read_en_o,
    output reg           irq_o,
    output reg           wake_o
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [N-1:0] sync1_q;
    reg  [N-1:0] sync2_q;
    reg          all_high_q;
    reg  [N-1:0] enable_q;
    reg          sens_q;
    reg          mask_q;
    reg          latch_q;
    reg          latch_d;
    reg          ack_pend_q;
    reg          ack_pend_d;
    wire         acc;
    wire         wr;
    wire         hit_sc;
    wire         hit_en;
    wire         all_high;
    wire         fall;
    wire         sw_ack;
    wire         ack;

    assign acc      = psel_i & penable_i;
    assign wr       = acc & pwrite_i;
    assign hit_sc   = (paddr_i == `KPI_ADDR_STATUS_CONTROL);
    assign hit_en   = (paddr_i == `KPI_ADDR_INPUT_ENABLE);
    // Disabled pins count as high so they never hold the request
    assign all_high = &(sync2_q | ~enable_q); // RQ1
    assign fall     = all_high_q & ~all_high; // RQ3 RQ4 RQ20
    // Break protects the latch from software ack unless clear-enable is set
    assign sw_ack   = wr & hit_sc & pwdata_i[`KPI_BIT_ACK]
                      & (~break_state_i | break_clear_enable_i); // RQ7 RQ17 RQ18
    assign ack      = sw_ack | vector_fetch_i; // RQ6

    // ------------------------------------------------------------
    // Synchroniser and combined edge detect
    // ------------------------------------------------------------
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_q    <= {N{1'b1}};
            sync2_q    <= {N{1'b1}};
            all_high_q <= 1'b1;
        end else begin
            sync1_q    <= keypad_input_pins_i; // RQ20
            sync2_q    <= sync1_q;
            all_high_q <= all_high;
        end
    end

    // ------------------------------------------------------------
    // Request latch
    // ------------------------------------------------------------
    // Level mode remembers an early ack until all pins are high again
    always @* begin
        latch_d = latch_q;
        if (sens_q) begin
            if ((ack || ack_pend_q) && all_high)
                latch_d = 1'b0; // RQ5
            if (!all_high)
                latch_d = 1'b1; // RQ5 RQ12
        end else if (ack) begin
            latch_d = 1'b0; // RQ6 RQ7
        end
        // Set wins over a same-cycle clear
        if (fall)
            latch_d = 1'b1; // RQ3 RQ8
        ack_pend_d = latch_d & (ack | ack_pend_q) & ~fall; // RQ5
    end

    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            latch_q  <= `KPI_RST_CTRL; // RQ13
            ack_pend_q <= 1'b0;
            sens_q   <= `KPI_RST_CTRL; // RQ13
            mask_q   <= `KPI_RST_CTRL; // RQ11
            enable_q <= `KPI_RST_ENABLE; // RQ14
        end else begin
            latch_q <= latch_d;
            ack_pend_q <= ack_pend_d;
            if (wr && hit_sc) begin
                sens_q <= pwdata_i[`KPI_BIT_SENSITIVITY]; // RQ12
                mask_q <= pwdata_i[`KPI_BIT_MASK]; // RQ11
            end
            if (wr && hit_en)
                enable_q <= pwdata_i[N-1:0]; // RQ1
        end
    end

    // ------------------------------------------------------------
    // Outputs and APB
    // ------------------------------------------------------------
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prdata_o      <= 32'h0000_0000;
            pready_o      <= 1'b0;
            pslverr_o     <= 1'b0;
            pullup_en_o   <= {N{1'b0}};
            force_input_o <= {N{1'b0}};
            pin_read_en_o <= {N{1'b0}};
            irq_o         <= 1'b0;
            wake_o        <= 1'b0;
        end else begin
            // No wait state: ready is high in the first access cycle, one cycle after setup
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & ~(hit_sc | hit_en);
            prdata_o  <= 32'h0000_0000;
            if (psel_i && !penable_i && !pwrite_i) begin
                if (hit_sc)
                    prdata_o <= {28'h0, latch_q, 1'b0, mask_q, sens_q}; // RQ7 RQ10
                else if (hit_en)
                    prdata_o <= {{(32-N){1'b0}}, enable_q};
            end
            pullup_en_o   <= enable_q; // RQ2
            force_input_o <= enable_q; // RQ15
            pin_read_en_o <= ~port_ddr_i; // RQ15
            irq_o         <= latch_q & ~mask_q; // RQ9 RQ11
            wake_o        <= latch_q & ~mask_q; // RQ16
        end
    end
endmodule // kpi_keypad_irq_unit
